// File: osdcd_params.svh
// Purpose: Constants for the on-screen display command decoder.
// Assumes: 25 MHz hclk; dot clock arrives as one-cycle pulses on hclk.
// Notes: Register offsets are byte addresses on the AHB-Lite slave.
`ifndef OSDCD_PARAMS_SVH
`define OSDCD_PARAMS_SVH
`define OSDCD_CLK_MHZ 25
`define OSDCD_CLR_WAIT_NS 10000
`define OSDCD_CLR_WAIT_CYC ((`OSDCD_CLR_WAIT_NS * `OSDCD_CLK_MHZ + 999) / 1000)
`define OSDCD_ROWS 12
`define OSDCD_COLS 24
`define OSDCD_DOTS_PER_CELL 12
`define OSDCD_H_OFFSET_DOTS 4
`define OSDCD_H_STEP_DOTS 12
`define OSDCD_BLINK_BIT_SLOW 5
`define OSDCD_BLINK_BIT_MID 4
`define OSDCD_BLINK_BIT_FAST 3
`define OSDCD_REG_CMD 12'h000
`define OSDCD_REG_STATUS 12'h004
`define OSDCD_REG_COLOUR 12'h008
`define OSDCD_REG_POSITION 12'h00c
`define OSDCD_DISP_OFF_CODE 8'hfe
`endif

// File: osdcd_pkg.sv
// Purpose: Types for the on-screen display command decoder.
// Assumes: Constants come from osdcd_params.svh.
// Notes: None.
package osdcd_pkg;
  typedef enum logic [1:0] {
    OSDCD_CLR_IDLE = 2'b00,
    OSDCD_CLR_WAIT = 2'b01,
    OSDCD_CLR_FILL = 2'b10
  } osdcd_clr_state_t;
endpackage : osdcd_pkg

// File: osdcd_command_decoder.sv
// Purpose: Serial command decoder, memory clear sequencer and pixel colouring.
// Assumes: All inputs synchronous to hclk; hresetn is the power-on clear.
// Notes: Software may also inject command bytes through the command register.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "osdcd_params.svh"
module osdcd_command_decoder
  import osdcd_pkg::*;
#(
  parameter bit LSB_FIRST = 1'b0,
  parameter int LINE_UNIT = 3,
  parameter logic [7:0] DISPLAY_OFF_CODE = `OSDCD_DISP_OFF_CODE
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial command link
  input wire logic ser_select,
  input wire logic ser_bit_valid,
  input wire logic ser_bit,
  // Timing and dot clock
  input wire logic dot_pulse,
  input wire logic ext_clock_sel,
  input wire logic test_pin_enable,
  input wire logic hsync_n,
  input wire logic vsync_n,
  output logic osc_enable,
  output logic display_start_h,
  output logic display_start_v,
  // Character memory
  input wire logic char_wr_valid,
  input wire logic [7:0] char_wr_code,
  input wire logic char_wr_blink,
  output logic vram_we,
  output logic [3:0] vram_row,
  output logic [4:0] vram_col,
  output logic [7:0] vram_wdata,
  output logic vram_wblink,
  output logic row_format_clear,
  // Pixel in
  input wire logic pix_fg,
  input wire logic pix_rim,
  input wire logic pix_bg,
  input wire logic cell_off,
  input wire logic cell_reverse,
  input wire logic cell_blink,
  input wire logic [2:0] char_colour,
  // Pixel out
  output logic [2:0] colour_rgb,
  output logic mono_channel_one,
  output logic mono_channel_two
);

  osdcd_clr_state_t clr_state;
  logic busy;
  logic [2:0] bit_cnt;
  logic [7:0] byte_sr;
  logic ser_done;
  logic [7:0] ser_byte;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic accept;
  logic have_first;
  logic [7:0] first_byte;
  logic start_clear;
  logic display_req;
  logic display_on;
  logic oscillator_run_bit;
  logic [1:0] blink_rate_select;
  logic [2:0] bg_colour;
  logic rim_colour_bit;
  logic [2:0] chan_on;
  logic global_reverse_enable;
  logic [4:0] horizontal_start_field;
  logic [4:0] vertical_start_field;
  logic [8:0] test_bits;
  logic hs_q;
  logic vs_q;
  logic hs_rise;
  logic hs_fall;
  logic vs_rise;
  logic dot_tick;
  logic [8:0] wait_cnt;
  logic [3:0] dot_cnt;
  logic [3:0] clr_row;
  logic [4:0] clr_col;
  logic cell_done;
  logic [3:0] wr_row;
  logic [4:0] wr_col;
  logic char_ok;
  logic por_pending;
  logic [8:0] hcnt;
  logic h_armed;
  logic [8:0] h_target;
  logic [8:0] lcnt;
  logic v_armed;
  logic [8:0] v_target;
  logic [5:0] frame_cnt;
  logic blink_hide;
  logic rev;
  logic lit;
  logic ahb_wr;
  logic [11:0] ahb_addr;
  logic ahb_cmd;
  logic [31:0] next_rdata;

  // Serial deframing into bytes; select low restarts the byte
  assign ser_byte = LSB_FIRST ? {ser_bit, byte_sr[7:1]} : {byte_sr[6:0], ser_bit};
  assign ser_done = ser_select && ser_bit_valid && (bit_cnt == 3'h7);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt <= 3'h0;
      byte_sr <= 8'h00;
    end else if (!ser_select) begin
      bit_cnt <= 3'h0;
    end else if (ser_bit_valid) begin
      byte_sr <= ser_byte;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Serial byte has priority over a byte written by software in the same cycle
  assign cmd_valid = ser_done || ahb_cmd;
  assign cmd_byte = ser_done ? ser_byte : hwdata[7:0];
  assign accept = cmd_valid && !busy;
  assign start_clear = accept && !have_first && (cmd_byte == 8'h00);

  // Command decode and control state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      have_first <= 1'b0;
      first_byte <= 8'h00;
      display_req <= 1'b0;
      oscillator_run_bit <= 1'b1;
      blink_rate_select <= 2'h0;
      bg_colour <= 3'h0;
      rim_colour_bit <= 1'b0;
      chan_on <= 3'h0;
      global_reverse_enable <= 1'b0;
      horizontal_start_field <= 5'h00;
      vertical_start_field <= 5'h00;
      test_bits <= 9'h000;
    end else if (start_clear) begin
      display_req <= 1'b0;
      oscillator_run_bit <= 1'b1;
    end else if (accept && have_first) begin
      have_first <= 1'b0;
      if (first_byte[7:2] == 6'b100000) begin
        vertical_start_field <= {first_byte[1:0], cmd_byte[7:5]};
        horizontal_start_field <= cmd_byte[4:0];
      end
      if (first_byte[7:1] == 7'b1011000 && test_pin_enable) begin
        test_bits <= {first_byte[0], cmd_byte};
      end
    end else if (accept) begin
      if (cmd_byte[7]) begin
        have_first <= 1'b1;
        first_byte <= cmd_byte;
      end else if (cmd_byte[7:4] == 4'h1) begin
        display_req <= cmd_byte[3];
        oscillator_run_bit <= cmd_byte[2];
        blink_rate_select <= cmd_byte[1:0];
      end else if (cmd_byte[7:4] == 4'h2) begin
        bg_colour <= cmd_byte[3:1];
        rim_colour_bit <= cmd_byte[0];
      end else if (cmd_byte[7:3] == 5'b01110) begin
        chan_on <= cmd_byte[2:0];
      end else if (cmd_byte[7:1] == 7'b0011100) begin
        global_reverse_enable <= cmd_byte[0];
      end
    end
  end

  // Sync edges
  assign hs_rise = hsync_n && !hs_q;
  assign hs_fall = !hsync_n && hs_q;
  assign vs_rise = vsync_n && !vs_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_q <= 1'b1;
      vs_q <= 1'b1;
    end else begin
      hs_q <= hsync_n;
      vs_q <= vsync_n;
    end
  end

  // Display bit follows the request on hsync falling edge; clear forces off at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      display_on <= 1'b0;
    end else if (start_clear) begin
      display_on <= 1'b0;
    end else if (hs_fall) begin
      display_on <= display_req;
    end
  end

  // Oscillator gating of the dot clock
  assign dot_tick = dot_pulse && oscillator_run_bit
    && (ext_clock_sel || !display_on || hsync_n);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= oscillator_run_bit && !ext_clock_sel && (!display_on || hsync_n);
    end
  end

  // Clear sequencer: settle wait, then one cell per 12 dot pulses
  assign busy = (clr_state != OSDCD_CLR_IDLE);
  assign cell_done = (clr_state == OSDCD_CLR_FILL) && dot_tick
    && (dot_cnt == 4'(`OSDCD_DOTS_PER_CELL - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_state <= OSDCD_CLR_WAIT;
      wait_cnt <= 9'h000;
      dot_cnt <= 4'h0;
      clr_row <= 4'h0;
      clr_col <= 5'h00;
    end else if (start_clear) begin
      clr_state <= OSDCD_CLR_WAIT;
      wait_cnt <= 9'h000;
    end else begin
      unique case (clr_state)
        OSDCD_CLR_IDLE: begin
          wait_cnt <= 9'h000;
        end
        OSDCD_CLR_WAIT: begin
          wait_cnt <= wait_cnt + 9'h001;
          dot_cnt <= 4'h0;
          clr_row <= 4'h0;
          clr_col <= 5'h00;
          if (wait_cnt == 9'(`OSDCD_CLR_WAIT_CYC - 1)) begin
            clr_state <= OSDCD_CLR_FILL;
          end
        end
        OSDCD_CLR_FILL: begin
          if (dot_tick) begin
            dot_cnt <= cell_done ? 4'h0 : dot_cnt + 4'h1;
          end
          if (cell_done) begin
            if (clr_col == 5'(`OSDCD_COLS - 1)) begin
              clr_col <= 5'h00;
              clr_row <= clr_row + 4'h1;
              if (clr_row == 4'(`OSDCD_ROWS - 1)) begin
                clr_state <= OSDCD_CLR_IDLE;
              end
            end else begin
              clr_col <= clr_col + 5'h01;
            end
          end
        end
        default: begin
          clr_state <= OSDCD_CLR_IDLE;
        end
      endcase
    end
  end

  // Character write pointer with row-major wrap
  assign char_ok = char_wr_valid && oscillator_run_bit && !busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_row <= 4'h0;
      wr_col <= 5'h00;
    end else if (start_clear) begin
      wr_row <= 4'h0;
      wr_col <= 5'h00;
    end else if (char_ok) begin
      if (wr_col == 5'(`OSDCD_COLS - 1)) begin
        wr_col <= 5'h00;
        wr_row <= (wr_row == 4'(`OSDCD_ROWS - 1)) ? 4'h0 : wr_row + 4'h1;
      end else begin
        wr_col <= wr_col + 5'h01;
      end
    end
  end

  // Character memory port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vram_we <= 1'b0;
      vram_row <= 4'h0;
      vram_col <= 5'h00;
      vram_wdata <= 8'h00;
      vram_wblink <= 1'b0;
      row_format_clear <= 1'b0;
      por_pending <= 1'b1;
    end else begin
      por_pending <= 1'b0;
      row_format_clear <= start_clear || por_pending;
      vram_we <= cell_done || char_ok;
      if (cell_done) begin
        vram_row <= clr_row;
        vram_col <= clr_col;
        vram_wdata <= DISPLAY_OFF_CODE;
        vram_wblink <= 1'b0;
      end else begin
        vram_row <= wr_row;
        vram_col <= wr_col;
        vram_wdata <= char_wr_code;
        vram_wblink <= char_wr_blink;
      end
    end
  end

  // Horizontal start: counted dot pulses after hsync rising edge
  assign h_target = 9'(`OSDCD_H_OFFSET_DOTS + `OSDCD_H_STEP_DOTS * (int'(horizontal_start_field) + 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcnt <= 9'h000;
      h_armed <= 1'b0;
      display_start_h <= 1'b0;
    end else begin
      display_start_h <= 1'b0;
      if (hs_rise) begin
        hcnt <= 9'h000;
        h_armed <= 1'b1;
      end else if (h_armed && dot_tick) begin
        hcnt <= hcnt + 9'h001;
        if (hcnt + 9'h001 == h_target) begin
          display_start_h <= 1'b1;
          h_armed <= 1'b0;
        end
      end
    end
  end

  // Vertical start: counted lines after vsync rising edge
  assign v_target = 9'(LINE_UNIT * int'(vertical_start_field) + 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lcnt <= 9'h000;
      v_armed <= 1'b0;
      display_start_v <= 1'b0;
    end else begin
      display_start_v <= 1'b0;
      if (vs_rise) begin
        lcnt <= 9'h000;
        v_armed <= 1'b1;
      end else if (v_armed && hs_rise) begin
        lcnt <= lcnt + 9'h001;
        if (lcnt + 9'h001 == v_target) begin
          display_start_v <= 1'b1;
          v_armed <= 1'b0;
        end
      end
    end
  end

  // Blink phase from frame count, 1:1 duty
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_cnt <= 6'h00;
    end else if (vs_rise) begin
      frame_cnt <= frame_cnt + 6'h01;
    end
  end

  always_comb begin
    unique case (blink_rate_select)
      2'h0: blink_hide = 1'b0;
      2'h1: blink_hide = frame_cnt[`OSDCD_BLINK_BIT_SLOW];
      2'h2: blink_hide = frame_cnt[`OSDCD_BLINK_BIT_MID];
      2'h3: blink_hide = frame_cnt[`OSDCD_BLINK_BIT_FAST];
    endcase
  end

  // Pixel colouring
  assign rev = global_reverse_enable && cell_reverse && !cell_off;
  assign lit = ((pix_fg && !(cell_blink && blink_hide)) ^ rev) && !cell_off;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      colour_rgb <= 3'h0;
      mono_channel_one <= 1'b0;
      mono_channel_two <= 1'b0;
    end else begin
      if (!(display_on && chan_on[2])) begin
        colour_rgb <= 3'h0;
      end else if (lit) begin
        colour_rgb <= char_colour;
      end else if (pix_rim) begin
        colour_rgb <= {3{rim_colour_bit}};
      end else if (pix_bg) begin
        colour_rgb <= bg_colour;
      end else begin
        colour_rgb <= 3'h0;
      end
      mono_channel_one <= display_on && chan_on[1] && lit;
      mono_channel_two <= display_on && chan_on[0] && lit;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ahb_cmd = ahb_wr && (ahb_addr == `OSDCD_REG_CMD);

  always_comb begin
    unique case (haddr)
      `OSDCD_REG_STATUS: next_rdata = {17'h0, test_bits != 9'h000, chan_on, bg_colour, rim_colour_bit,
        global_reverse_enable, blink_rate_select, oscillator_run_bit, display_req, display_on, busy};
      `OSDCD_REG_COLOUR: next_rdata = {24'h0, chan_on, global_reverse_enable, bg_colour, rim_colour_bit};
      `OSDCD_REG_POSITION: next_rdata = {7'h0, test_bits, 3'h0, vertical_start_field, 3'h0,
        horizontal_start_field};
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr <= 1'b0;
      ahb_addr <= 12'h000;
      hrdata <= 32'h0;
    end else begin
      ahb_wr <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        ahb_wr <= hwrite;
        ahb_addr <= haddr;
        if (!hwrite) begin
          hrdata <= next_rdata;
        end
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_clear_busy: assert property (start_clear |=> busy ##1 busy) else $error("clear did not raise busy");
  a_clear_cell: assert property (vram_we && busy |-> vram_wdata == DISPLAY_OFF_CODE && !vram_wblink)
    else $error("clear wrote wrong cell value");
  a_clear_ptr: assert property (start_clear |=> wr_row == 4'h0 && wr_col == 5'h00 && row_format_clear)
    else $error("clear left pointer or rows");
  a_clear_osc: assert property (start_clear |=> oscillator_run_bit && !display_on && !display_req)
    else $error("clear left display or oscillator");
  a_fill_dots: assert property (vram_we && busy |-> $past(dot_tick)) else $error("cell cleared without dot");
  a_test_kept: assert property (start_clear |=> $stable(test_bits)) else $error("clear touched test mode");
  a_osc_gate: assert property (char_wr_valid && !oscillator_run_bit |=> !vram_we)
    else $error("write with oscillator off");
  a_disp_edge: assert property ($rose(display_on) |-> $past(hs_fall)) else $error("display on off-edge");
  a_busy_drop: assert property (ser_done && busy && !start_clear |=> $stable(chan_on) && $stable(have_first))
    else $error("byte taken while busy");
  a_mono_dark: assert property (cell_off |=> !mono_channel_one && !mono_channel_two)
    else $error("off cell lit on mono");
  a_hstart_span: assert property (hs_rise |=> !display_start_h [*8]) else $error("early horizontal start");

  c_clear_done: cover property ($fell(busy));
  c_position: cover property (accept && have_first && first_byte[7:2] == 6'b100000);
  c_hstart: cover property (display_start_h);
  c_vstart: cover property (display_start_v);

endmodule : osdcd_command_decoder

// File: osdcd_host_model.sv
// Purpose: Host side of the serial command link for the display decoder.
// Assumes: One byte or two bytes per request, high byte first.
// Notes: The data line toggles every cycle when it carries no bit.
`timescale 1ns/100ps
module osdcd_host_model #(
  parameter bit LSB_FIRST = 1'b0
) (
  // Clock
  input wire logic hclk,
  // Request
  input wire logic go,
  input wire logic slow,
  input wire logic [4:0] n_bits,
  input wire logic [15:0] word,
  // Serial link
  output logic ser_select,
  output logic ser_bit_valid,
  output logic ser_bit,
  output logic busy
);
  logic [15:0] sh = 16'h0000;
  logic [4:0] left = 5'h00;
  logic gap = 1'b0;

  initial begin
    ser_select = 1'b0;
    ser_bit_valid = 1'b0;
    ser_bit = 1'b0;
    busy = 1'b0;
  end

  always @(posedge hclk) begin
    if (busy && left != 5'd0 && !gap) begin
      ser_bit_valid <= 1'b1;
      ser_bit <= LSB_FIRST ? sh[0] : sh[15];
      sh <= LSB_FIRST ? (sh >> 1) : (sh << 1);
      left <= left - 5'd1;
      gap <= slow;
    end else begin
      // No bit this cycle: the data line shows the inverse of its last value
      ser_bit_valid <= 1'b0;
      ser_bit <= ~ser_bit;
      gap <= 1'b0;
      if (go && !busy) begin
        if (LSB_FIRST) begin
          sh <= (n_bits == 5'd16) ? {word[7:0], word[15:8]} : {8'h00, word[7:0]};
        end else begin
          sh <= (n_bits == 5'd16) ? word : {word[7:0], 8'h00};
        end
        left <= n_bits;
        busy <= 1'b1;
        ser_select <= 1'b1;
      end else if (busy && left == 5'd0) begin
        ser_select <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule : osdcd_host_model

// File: osd_command_decoder_test.sv
// Purpose: Self-checking bench for the display command decoder.
// Assumes: External dot clock selected until the osc_enable check; MSB-first serial order.
// Notes: Drivers queue expected results; monitors match them.
`timescale 1ns/100ps
`include "osdcd_params.svh"
module osd_command_decoder_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_ph = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic ser_select, ser_bit_valid, ser_bit, hm_busy;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [4:0] nbits = 5'd8;
  logic [15:0] word = 16'h0000;
  logic dot_pulse = 1'b0;
  logic dot_en = 1'b1;
  logic hsync_n = 1'b1;
  logic hsync_q = 1'b1;
  logic vsync_n = 1'b1;
  logic vsync_q = 1'b1;
  logic ext_sel = 1'b1;
  logic pix_on = 1'b0;
  logic pv1 = 1'b0;
  logic pv2 = 1'b0;
  logic don = 1'b1;
  logic display_start_v, osc_enable, row_format_clear, mono_one, mono_two;
  logic [2:0] colour_rgb;
  logic [8:0] pr, tb;
  logic [4:0] pe;
  logic display_start_h, vram_we, vram_wblink;
  logic [3:0] vram_row;
  logic [4:0] vram_col;
  logic [7:0] vram_wdata;
  logic char_wr_valid = 1'b0;
  logic char_wr_blink = 1'b0;
  logic [7:0] char_wr_code = 8'h00;
  logic [8:0] pix = 9'h000;
  logic [2:0] ch, bg;
  logic rim, rv;
  logic [4:0] ph, pv;
  logic [63:0] e;
  logic [17:0] ve;
  logic [63:0] exp_q[$];
  logic [17:0] vq[$];
  int hq[$];
  int lq[$];
  logic [4:0] pq[$];
  int n_errors = 0;
  int samples_checked = 0;
  int hcnt = 0;
  int lcnt = 0;
  int nrfc = 0;

  always #20 hclk = ~hclk;
  always @(posedge hclk) dot_pulse <= dot_en & ~dot_pulse;

  osdcd_command_decoder dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .ser_select(ser_select), .ser_bit_valid(ser_bit_valid), .ser_bit(ser_bit), .dot_pulse(dot_pulse),
    .ext_clock_sel(ext_sel), .test_pin_enable(1'b1), .hsync_n(hsync_n), .vsync_n(vsync_n),
    .osc_enable(osc_enable), .display_start_h(display_start_h), .display_start_v(display_start_v),
    .char_wr_valid(char_wr_valid),
    .char_wr_code(char_wr_code), .char_wr_blink(char_wr_blink), .vram_we(vram_we), .vram_row(vram_row),
    .vram_col(vram_col), .vram_wdata(vram_wdata), .vram_wblink(vram_wblink), .row_format_clear(row_format_clear),
    .pix_fg(pix[8]), .pix_rim(pix[7]), .pix_bg(pix[6]), .cell_off(pix[5]), .cell_reverse(pix[4]),
    .cell_blink(pix[3]), .char_colour(pix[2:0]), .colour_rgb(colour_rgb), .mono_channel_one(mono_one),
    .mono_channel_two(mono_two));

  osdcd_host_model host_u (
    .hclk(hclk), .go(go), .slow(slow), .n_bits(nbits), .word(word), .ser_select(ser_select),
    .ser_bit_valid(ser_bit_valid), .ser_bit(ser_bit), .busy(hm_busy));

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] m,
                     input logic [31:0] ex);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 100);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    if (!wr) begin
      exp_q.push_back({m, ex & m});
      rd_ph <= 1'b1;
    end
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 100);
    rd_ph <= 1'b0;
  endtask : bus

  task automatic ser(input logic [15:0] w, input logic [4:0] n);
    int k;
    k = 0;
    word <= w;
    nbits <= n;
    slow <= 1'($urandom_range(1));
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    do @(posedge hclk); while (hm_busy && ++k < 200);
  endtask : ser

  task automatic hline();
    int k;
    k = 0;
    dot_en <= 1'b0;
    hsync_n <= 1'b0;
    repeat (4) @(posedge hclk);
    hsync_n <= 1'b1;
    hq.push_back(4 + 12 * (ph + 1));
    repeat (2) @(posedge hclk);
    dot_en <= 1'b1;
    do @(posedge hclk); while (hq.size() != 0 && ++k < 1000);
  endtask : hline

  task automatic vframe();
    dot_en <= 1'b0;
    vsync_n <= 1'b0;
    repeat (2) @(posedge hclk);
    vsync_n <= 1'b1;
    lq.push_back(3 * pv + 1);
    repeat (3 * pv + 2) begin
      repeat (2) @(posedge hclk);
      hsync_n <= 1'b0;
      repeat (2) @(posedge hclk);
      hsync_n <= 1'b1;
    end
    repeat (4) @(posedge hclk);
  endtask : vframe

  task automatic cw(input logic exp, input logic [4:0] col);
    logic [8:0] r;
    r = 9'($urandom);
    if (exp) vq.push_back({4'h0, col, r});
    char_wr_code <= r[8:1];
    char_wr_blink <= r[0];
    char_wr_valid <= 1'b1;
    @(posedge hclk);
    char_wr_valid <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : cw

  task automatic push_clear();
    for (int r = 0; r < 12; r++) for (int c = 0; c < 24; c++) vq.push_back({4'(r), 5'(c), 8'hfe, 1'b0});
  endtask : push_clear

  task automatic wait_clear();
    int k;
    k = 0;
    do @(posedge hclk); while (vq.size() != 0 && ++k < 9000);
    repeat (4) @(posedge hclk);
  endtask : wait_clear

  function automatic logic [31:0] st(input logic don, input logic [1:0] bl);
    return {18'h0, ch, bg, rim, rv, bl, 1'b1, 1'b1, don, 1'b0};
  endfunction : st

  // Expected pixel word {rgb, one, two}; vsync stays quiet meanwhile, so blinking never hides
  function automatic logic [4:0] pexp(input logic [8:0] p);
    logic rvs, lt;
    logic [2:0] c;
    rvs = rv & p[4] & !p[5];
    lt = (p[8] ^ rvs) & !p[5];
    c = 3'h0;
    if (don && ch[2]) c = lt ? p[2:0] : (p[7] ? {3{rim}} : (p[6] ? bg : 3'h0));
    return {c, don & ch[1] & lt, don & ch[0] & lt};
  endfunction : pexp

  // Pixel stimulus; expected colours noted while the display state is known
  always @(posedge hclk) begin
    if (hresetn) begin
      pr = 9'($urandom);
      pix <= pr;
      if (pix_on) pq.push_back(pexp(pr));
    end
    pv1 <= hresetn && pix_on;
    pv2 <= pv1;
  end

  // Monitors: bus reads, memory writes, horizontal and vertical start timing, pixel outputs
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      e = exp_q.size() ? exp_q.pop_front() : {32'hffffffff, 32'hx};
      chk(hrdata & e[63:32], e[31:0]);
    end
    if (vram_we) begin
      ve = vq.size() ? vq.pop_front() : 18'hx;
      chk(32'({vram_row, vram_col, vram_wdata, vram_wblink}), 32'(ve));
    end
    if (display_start_h) chk(32'(hcnt), hq.size() ? 32'(hq.pop_front()) : 32'hx);
    if (!hsync_q && hsync_n) hcnt = 0;
    else hcnt += int'(dot_pulse);
    if (pv2) begin
      pe = pq.size() ? pq.pop_front() : 5'hx;
      chk(32'({colour_rgb, mono_one, mono_two}), 32'(pe));
    end
    if (display_start_v) chk(32'(lcnt), lq.size() ? 32'(lq.pop_front()) : 32'hx);
    if (!vsync_q && vsync_n) lcnt = 0;
    else if (!hsync_q && hsync_n) lcnt++;
    if (row_format_clear) nrfc++;
    vsync_q <= vsync_n;
    hsync_q <= hsync_n;
  end

  initial begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(57));
    push_clear();
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    wait_clear();
    for (int i = 0; i < 3; i++) begin
      {ch, bg, rim, rv} = 8'($urandom);
      ser({8'h00, 5'b01110, ch}, 5'd8);
      ser({8'h00, 4'b0010, bg, rim}, 5'd8);
      ser({8'h00, 7'b0011100, rv}, 5'd8);
      bus(1'b0, `OSDCD_REG_COLOUR, 32'h0, 32'hff, {24'h0, ch, rv, bg, rim});
    end
    {pv, ph} = 10'($urandom);
    tb = 9'($urandom);
    ser({6'b100000, pv, ph}, 5'd16);
    ser({7'b1011000, tb}, 5'd16);
    bus(1'b0, `OSDCD_REG_POSITION, 32'h0, 32'h01ff1f1f, {7'h0, tb, 3'h0, pv, 3'h0, ph});
    bus(1'b0, 12'h0f0, 32'h0, 32'hffffffff, 32'h0);
    ser(16'h001d, 5'd8);
    bus(1'b0, `OSDCD_REG_STATUS, 32'h0, 32'h3fff, st(1'b0, 2'b01));
    hline();
    pix_on <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      ser(16'(8'h1c | b), 5'd8);
      bus(1'b0, `OSDCD_REG_STATUS, 32'h0, 32'h3fff, st(1'b1, 2'(b)));
    end
    ser(16'h0018, 5'd8);
    cw(1'b0, 5'h00);
    ser(16'h001c, 5'd8);
    cw(1'b1, 5'h00);
    cw(1'b1, 5'h01);
    pix_on <= 1'b0;
    push_clear();
    bus(1'b1, `OSDCD_REG_CMD, 32'h0, 32'h0, 32'h0);
    ser(16'(8'h38 | !rv), 5'd8);
    wait_clear();
    bus(1'b0, `OSDCD_REG_COLOUR, 32'h0, 32'hff, {24'h0, ch, rv, bg, rim});
    bus(1'b0, `OSDCD_REG_STATUS, 32'h0, 32'hf, 32'h8);
    bus(1'b0, `OSDCD_REG_POSITION, 32'h0, 32'h01ff1f1f, {7'h0, tb, 3'h0, pv, 3'h0, ph});
    don = 1'b0;
    pix_on <= 1'b1;
    cw(1'b1, 5'h00);
    pix_on <= 1'b0;
    chk(32'(osc_enable), 32'h0);
    ext_sel <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(32'(osc_enable), 32'h1);
    vframe();
    chk(32'(nrfc), 32'h2);
    chk(32'(exp_q.size() + vq.size() + hq.size() + lq.size() + pq.size()), 32'h0);
    tally_and_finish();
  end
endmodule : osd_command_decoder_test
